// >>> flash_self_program_sequencer.sv
// Run-time self-programming sequencer with its flash array and registers.
// Assumes an AXI4-Lite master that offers address and data together.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module flash_self_program_sequencer (
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_b_i,
   input  wire flash_seq_pkg::axil_req_t axi_req_i,
   output flash_seq_pkg::axil_rsp_t      axi_rsp_o,
   output logic                          core_stall_o
);
   import flash_seq_pkg::*;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   logic [WORD_W-1:0] flash_mem [ARRAY_WORDS];

   logic              ctrl_go_q;
   logic              ctrl_mtype_q;
   op_t               ctrl_op_q;
   logic [ADDR_W-1:0] ptr_q;
   logic              reject_q;
   key_state_t        key_st_q;
   seq_state_t        seq_st_q;
   logic [RUN_W-1:0]  idx_q;
   logic [ADDR_W-1:0] base_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              hold_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;

   logic              wr_take;
   logic              ar_take;
   logic              w_ctrl;
   logic              w_key;
   logic              w_ptr;
   logic              w_data;
   logic              w_stat;
   logic              w_err;
   logic              start_req;
   logic              start;
   logic [RUN_W-1:0]  run_last;
   logic [ADDR_W-1:0] seq_addr;
   logic [WORD_W-1:0] lat_rd;
   logic [31:0]       rdata_d;
   logic [1:0]        rresp_d;

   // Writes wait while a cycle runs, so the core's bus master stalls too
   assign wr_take = axi_req_i.awvalid && axi_req_i.wvalid && !bvalid_q
                    && !hold_q && seq_st_q == ST_IDLE;
   assign ar_take = axi_req_i.arvalid && !rvalid_q;

   always_comb begin
      w_ctrl = 1'b0;
      w_key  = 1'b0;
      w_ptr  = 1'b0;
      w_data = 1'b0;
      w_stat = 1'b0;
      w_err  = 1'b0;
      if (axi_req_i.awaddr == CTRL_OFS) begin
         w_ctrl = 1'b1;
      end else if (axi_req_i.awaddr == KEY_OFS) begin
         w_key = 1'b1;
      end else if (axi_req_i.awaddr == PTR_OFS) begin
         w_ptr = 1'b1;
      end else if (axi_req_i.awaddr == DATA_OFS) begin
         w_data = 1'b1;
      end else if (axi_req_i.awaddr == STAT_OFS) begin
         w_stat = 1'b1;
      end else begin
         w_err = 1'b1;
      end
   end

   assign start_req = w_ctrl && axi_req_i.wstrb[1]
                      && axi_req_i.wdata[CTRL_GO_BIT];
   // Only flash memory type and a real operation may start
   assign start = wr_take && start_req && key_st_q == KEY_ARMED
                  && !axi_req_i.wdata[CTRL_MTYPE_BIT]
                  && axi_req_i.wdata[1:0] != OP_NONE;

   // Unlock key: any other write between the pair breaks the sequence
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_st_q <= KEY_IDLE;
      end else if (wr_take) begin
         if (w_key && axi_req_i.wdata[7:0] == KEY_FIRST) begin
            key_st_q <= KEY_HALF;
         end else if (w_key && axi_req_i.wdata[7:0] == KEY_SECOND
                      && key_st_q == KEY_HALF) begin
            key_st_q <= KEY_ARMED;
         end else begin
            key_st_q <= KEY_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_op_q    <= OP_NONE;
         ctrl_mtype_q <= 1'b0;
      end else if (wr_take && w_ctrl) begin
         if (axi_req_i.wstrb[0]) begin
            ctrl_op_q <= op_t'(axi_req_i.wdata[1:0]);
         end
         if (axi_req_i.wstrb[1]) begin
            ctrl_mtype_q <= axi_req_i.wdata[CTRL_MTYPE_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_go_q <= 1'b0;
      end else if (start) begin
         ctrl_go_q <= 1'b1;
      end else if (seq_st_q == ST_DONE) begin
         ctrl_go_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr_q <= '0;
      end else if (wr_take && w_ptr) begin
         if (axi_req_i.wstrb[0]) begin
            ptr_q[7:0] <= axi_req_i.wdata[7:0];
         end
         if (axi_req_i.wstrb[1]) begin
            ptr_q[ADDR_W-1:8] <= axi_req_i.wdata[ADDR_W-1:8];
         end
      end
   end

   // A refused start sets the sticky flag; the set wins over a clear
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reject_q <= 1'b0;
      end else if (wr_take && start_req && !start) begin
         reject_q <= 1'b1;
      end else if (wr_take && w_stat && axi_req_i.wstrb[0]
                   && axi_req_i.wdata[STAT_REJ_BIT]) begin
         reject_q <= 1'b0;
      end
   end

   row_latch_bank u_latch (
      .sys_clk_i   (sys_clk_i),
      .load_i      (wr_take && w_data),
      .load_idx_i  (ptr_q[IDX_W-1:0]),
      .load_data_i (axi_req_i.wdata[WORD_W-1:0]),
      .rd_idx_i    (seq_addr[IDX_W-1:0]),
      .rd_data_o   (lat_rd)
   );

   always_comb begin
      case (ctrl_op_q)
         OP_ERASE: run_last = ERASE_LAST;
         OP_ROW:   run_last = ROW_LAST;
         default:  run_last = WORD_LAST;
      endcase
   end

   assign seq_addr = base_q + ADDR_W'(idx_q);

   // Sequencer: walk the words of the target, then wait out the cell time
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seq_st_q <= ST_IDLE;
         idx_q    <= '0;
         base_q   <= '0;
         cnt_q    <= '0;
      end else begin
         case (seq_st_q)
            ST_IDLE: begin
               if (start) begin
                  seq_st_q <= ST_WRITE;
                  idx_q    <= '0;
                  if (axi_req_i.wdata[1:0] == OP_ERASE) begin
                     base_q <= {ptr_q[ADDR_W-1], 9'h000};
                  end else if (axi_req_i.wdata[1:0] == OP_ROW) begin
                     base_q <= {ptr_q[ADDR_W-1:IDX_W], 6'h00};
                  end else begin
                     base_q <= ptr_q;
                  end
               end
            end
            ST_WRITE: begin
               if (idx_q == run_last) begin
                  seq_st_q <= ST_WAIT;
                  cnt_q    <= (ctrl_op_q == OP_ERASE) ? ERASE_CYC : PROG_CYC;
               end else begin
                  idx_q <= idx_q + 9'h001;
               end
            end
            ST_WAIT: begin
               if (cnt_q == 12'h001) begin
                  seq_st_q <= ST_DONE;
               end else begin
                  cnt_q <= cnt_q - 12'h001;
               end
            end
            default: begin
               seq_st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Programming only clears bits, like a real cell; erase sets them all
   always_ff @(posedge sys_clk_i) begin
      if (seq_st_q == ST_WRITE) begin
         if (ctrl_op_q == OP_ERASE) begin
            flash_mem[seq_addr] <= ERASED_WORD;
         end else begin
            flash_mem[seq_addr] <= flash_mem[seq_addr] & lat_rd;
         end
      end
   end

   // A table write answers on the edge after it is taken
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
         hold_q   <= 1'b0;
      end else begin
         if (wr_take) begin
            bresp_q <= w_err ? RESP_SLVERR : RESP_OKAY;
         end
         if (start) begin
            hold_q <= 1'b1;
         end else if (wr_take) begin
            bvalid_q <= 1'b1;
         end else if (seq_st_q == ST_DONE) begin
            hold_q   <= 1'b0;
            bvalid_q <= 1'b1;
         end else if (axi_req_i.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      rresp_d = RESP_OKAY;
      if (axi_req_i.araddr == CTRL_OFS) begin
         rdata_d[CTRL_GO_BIT]    = ctrl_go_q;
         rdata_d[CTRL_MTYPE_BIT] = ctrl_mtype_q;
         rdata_d[1:0]            = ctrl_op_q;
      end else if (axi_req_i.araddr == KEY_OFS) begin
         rdata_d = 32'h0000_0000;
      end else if (axi_req_i.araddr == PTR_OFS) begin
         rdata_d[ADDR_W-1:0] = ptr_q;
      end else if (axi_req_i.araddr == DATA_OFS) begin
         rdata_d = 32'h0000_0000;
      end else if (axi_req_i.araddr == RDAT_OFS) begin
         rdata_d[WORD_W-1:0] = flash_mem[ptr_q];
      end else if (axi_req_i.araddr == STAT_OFS) begin
         rdata_d[STAT_BUSY_BIT]  = seq_st_q != ST_IDLE;
         rdata_d[STAT_ARMED_BIT] = key_st_q == KEY_ARMED;
         rdata_d[STAT_REJ_BIT]   = reject_q;
      end else begin
         rresp_d = RESP_SLVERR;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end else if (axi_req_i.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_comb begin
      axi_rsp_o         = '0;
      axi_rsp_o.awready = wr_take;
      axi_rsp_o.wready  = wr_take;
      axi_rsp_o.bvalid  = bvalid_q;
      axi_rsp_o.bresp   = bresp_q;
      axi_rsp_o.arready = !rvalid_q;
      axi_rsp_o.rvalid  = rvalid_q;
      axi_rsp_o.rdata   = rdata_q;
      axi_rsp_o.rresp   = rresp_q;
   end

   assign core_stall_o = hold_q;

   row_span_a: assert property (
      seq_st_q == ST_WRITE && ctrl_op_q == OP_ROW
      |-> base_q[IDX_W-1:0] == 6'h00
          && seq_addr[ADDR_W-1:IDX_W] == base_q[ADDR_W-1:IDX_W])
      else $error("row program left its row");

   erase_len_a: assert property (
      seq_st_q == ST_WRITE ##1 seq_st_q == ST_WAIT && ctrl_op_q == OP_ERASE
      |-> $past(idx_q) == ERASE_LAST && base_q[8:0] == 9'h000)
      else $error("erase did not cover one aligned block");

   word_one_a: assert property (
      seq_st_q == ST_IDLE ##1 seq_st_q == ST_WRITE && ctrl_op_q == OP_WORD
      |=> seq_st_q == ST_WAIT)
      else $error("word program wrote more than one word");

   tbl_load_a: assert property (
      wr_take && w_data |=> axi_rsp_o.bvalid && seq_st_q == ST_IDLE)
      else $error("table write not done in two cycles");

   go_clear_a: assert property (
      seq_st_q == ST_DONE |=> !ctrl_go_q && seq_st_q == ST_IDLE
                              && axi_rsp_o.bvalid)
      else $error("go bit not cleared at completion");

   stall_hold_a: assert property (
      start |=> (core_stall_o && !axi_rsp_o.bvalid
                 && !axi_rsp_o.awready) [*8])
      else $error("core not stalled during operation");

   // Arming only ever follows a first key value and a taken key write
   key_gate_a: assert property (
      key_st_q == KEY_ARMED && $past(key_st_q) != KEY_ARMED
      |-> $past(key_st_q) == KEY_HALF && $past(wr_take && w_key))
      else $error("key armed without key pair");

   key_reject_a: assert property (
      wr_take && start_req && key_st_q != KEY_ARMED
      |=> !ctrl_go_q && reject_q && seq_st_q == ST_IDLE)
      else $error("unkeyed start was not ignored");

   erase_run_c: cover property (
      seq_st_q == ST_DONE && ctrl_op_q == OP_ERASE);
   row_run_c: cover property (
      seq_st_q == ST_DONE && ctrl_op_q == OP_ROW);
   word_run_c: cover property (
      seq_st_q == ST_DONE && ctrl_op_q == OP_WORD);
   reject_c: cover property ($rose(reject_q));

endmodule

// >>> flash_seq_pkg.sv
// Constants, types and register map of the flash self-program sequencer.
// Assumes a 125 MHz system clock and an AXI4-Lite master with 32-bit data.
// What this block does
// - Flash rows hold 64 instruction words, which is 192 bytes.
// - Erase clears eight consecutive rows (512 words); program writes one row.
// - A single instruction word can also be programmed.
// - Erase blocks align on 1536 bytes, rows on 192 bytes, from address zero.
// - Table writes only fill holding latches; only a sequence changes the array.
// - Any number of latch loads is fine; 64 fill a whole row.
// - Latches load in any order; the latest load of a latch wins.
// - Each table write is one word, finished in two cycles.
// - Each row needs its own programming cycle, launched by software.
// - Key register is write-only; 55h then AAh must precede a start.
// - Control register picks erase or program, memory type, and start.
// - Bit 15 of control starts the operation; hardware clears it at end.
// - The processor is stalled until a program or erase finishes.
package flash_seq_pkg;

   localparam int ROW_WORDS     = 64;
   localparam int ROW_BYTES     = 192;
   localparam int BLOCK_WORDS   = 512;
   localparam int BLOCK_BYTES   = 1536;
   localparam int WORD_W        = 24;
   localparam int ADDR_W        = 10;
   localparam int IDX_W         = 6;
   localparam int RUN_W         = 9;
   localparam int ARRAY_WORDS   = 1024;
   localparam int AXI_AW        = 12;
   localparam int CNT_W         = 12;

   localparam logic [AXI_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [AXI_AW-1:0] KEY_OFS  = 12'h004;
   localparam logic [AXI_AW-1:0] PTR_OFS  = 12'h008;
   localparam logic [AXI_AW-1:0] DATA_OFS = 12'h00c;
   localparam logic [AXI_AW-1:0] RDAT_OFS = 12'h010;
   localparam logic [AXI_AW-1:0] STAT_OFS = 12'h014;

   localparam int CTRL_GO_BIT    = 15;
   localparam int CTRL_MTYPE_BIT = 14;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_ARMED_BIT = 1;
   localparam int STAT_REJ_BIT   = 2;

   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam logic [WORD_W-1:0] ERASED_WORD = 24'hffffff;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   localparam logic [RUN_W-1:0] WORD_LAST  = 9'h000;
   localparam logic [RUN_W-1:0] ROW_LAST   = 9'h03f;
   localparam logic [RUN_W-1:0] ERASE_LAST = 9'h1ff;

   localparam int CLK_PERIOD_NS = 8;
   localparam int PROG_TIME_NS  = 2000;
   localparam int ERASE_TIME_NS = 4000;
   localparam logic [CNT_W-1:0] PROG_CYC =
      CNT_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ERASE_CYC =
      CNT_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_WORD  = 2'b01,
      OP_ROW   = 2'b10,
      OP_ERASE = 2'b11
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_WAIT  = 2'b11,
      ST_DONE  = 2'b10
   } seq_state_t;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_HALF  = 2'b01,
      KEY_ARMED = 2'b11
   } key_state_t;

   typedef struct packed {
      logic              awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [AXI_AW-1:0] araddr;
      logic              rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

endpackage

// >>> row_latch_bank.sv
// Row-wide holding latches filled by table writes.
// Assumes one load at a time; contents are undefined after reset.
module row_latch_bank (
   input  wire logic                              sys_clk_i,
   input  wire logic                              load_i,
   input  wire logic [flash_seq_pkg::IDX_W-1:0]   load_idx_i,
   input  wire logic [flash_seq_pkg::WORD_W-1:0]  load_data_i,
   input  wire logic [flash_seq_pkg::IDX_W-1:0]   rd_idx_i,
   output logic      [flash_seq_pkg::WORD_W-1:0]  rd_data_o
);
   import flash_seq_pkg::*;

   logic [WORD_W-1:0] lat_q [ROW_WORDS];

   // No reset on purpose: software must fill unused slots with all ones
   for (genvar i = 0; i < ROW_WORDS; i++) begin : g_lat
      always_ff @(posedge sys_clk_i) begin
         if (load_i && load_idx_i == IDX_W'(i)) begin
            lat_q[i] <= load_data_i;
         end
      end
   end

   assign rd_data_o = lat_q[rd_idx_i];

endmodule

// >>> core_bus_model.sv
// Processor-core model: AXI4-Lite master issuing table writes and control writes.
// Assumes the sequencer withholds bvalid of an accepted start until the operation ends.
module core_bus_model (
   input  wire logic                     sys_clk_i,
   output flash_seq_pkg::axil_req_t      req_o,
   input  wire flash_seq_pkg::axil_rsp_t rsp_i,
   input  wire logic                     stall_i
);
   timeunit 1ns;
   timeprecision 100ps;
   import flash_seq_pkg::*;

   initial req_o = '0;

   task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] dat,
                     output logic [1:0] resp, output int stl);
      stl = 0;
      @(posedge sys_clk_i);
      req_o.awvalid <= 1'b1;
      req_o.wvalid  <= 1'b1;
      req_o.awaddr  <= a;
      req_o.wdata   <= dat;
      req_o.wstrb   <= 4'hf;
      req_o.bready  <= 1'b1;
      do @(posedge sys_clk_i); while (rsp_i.awready !== 1'b1 || rsp_i.wready !== 1'b1);
      req_o.awvalid <= 1'b0;
      req_o.wvalid  <= 1'b0;
      // Released lines carry the inverse so a stale value never looks valid
      req_o.awaddr  <= ~a;
      req_o.wdata   <= ~dat;
      while (rsp_i.bvalid !== 1'b1) begin
         @(posedge sys_clk_i);
         stl += int'(stall_i);
      end
      resp = rsp_i.bresp;
      req_o.bready <= 1'b0;
   endtask

   task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] dat,
                     output logic [1:0] resp);
      @(posedge sys_clk_i);
      req_o.arvalid <= 1'b1;
      req_o.araddr  <= a;
      req_o.rready  <= 1'b1;
      do @(posedge sys_clk_i); while (rsp_i.arready !== 1'b1);
      req_o.arvalid <= 1'b0;
      req_o.araddr  <= ~a;
      while (rsp_i.rvalid !== 1'b1) @(posedge sys_clk_i);
      dat = rsp_i.rdata;
      resp = rsp_i.rresp;
      req_o.rready <= 1'b0;
   endtask

   // Key pair and go as three writes in a row; any write between disarms
   task automatic launch(input logic [31:0] ctrl, output logic [1:0] resp,
                         output int stl);
      logic [1:0] r;
      int         s;
      wr(KEY_OFS, {24'h0, KEY_FIRST}, r, s);
      wr(KEY_OFS, {24'h0, KEY_SECOND}, r, s);
      wr(CTRL_OFS, ctrl, resp, stl);
   endtask
endmodule

// >>> flash_self_program_sequencer_tb.sv
// Self-checking bench: array and latch model compared with register reads.
// Assumes the core model drives the bus; flash contents are trusted only after erase.
module flash_self_program_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import flash_seq_pkg::*;

   logic        sys_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   axil_req_t   req;
   axil_rsp_t   rsp;
   logic        stall;
   int          err_count  = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   int          s;
   logic [31:0] seed       = 32'h4086;
   logic [31:0] d;
   logic [1:0]  r;
   logic [23:0] flash_m [ARRAY_WORDS];
   logic [23:0] latch_m [ROW_WORDS];

   flash_self_program_sequencer dut (
      .sys_clk_i   (sys_clk_i),
      .rst_b_i     (rst_b_i),
      .axi_req_i   (req),
      .axi_rsp_o   (rsp),
      .core_stall_o(stall)
   );

   core_bus_model core (
      .sys_clk_i(sys_clk_i),
      .req_o    (req),
      .rsp_i    (rsp),
      .stall_i  (stall)
   );

   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run is near 13k cycles; the ceiling leaves ample margin
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end

   task automatic sweep(input int lo, input int hi);
      for (int a = lo; a <= hi; a++) begin
         core.wr(PTR_OFS, 32'(a), r, s);
         core.rd(RDAT_OFS, d, r);
         check(d, {8'h0, flash_m[a]});
      end
   endtask

   task automatic load(input int a, input logic [23:0] v);
      core.wr(PTR_OFS, 32'(a), r, s);
      core.wr(DATA_OFS, {8'h0, v}, r, s);
      latch_m[a % ROW_WORDS] = v;
   endtask

   task automatic op_done(input int n);
      check(32'(r), 32'(RESP_OKAY));
      check(32'(s >= n && s <= n + 2), 32'h1);
      core.rd(CTRL_OFS, d, r);
      check(32'(d[CTRL_GO_BIT]), 32'h0);
   endtask

   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      core.rd(STAT_OFS, d, r);
      check(d, 32'h0);
      core.rd(KEY_OFS, d, r);
      check(d, 32'h0);
      core.rd(12'h020, d, r);
      check(32'(r), 32'(RESP_SLVERR));
      core.wr(12'h020, 32'h0, r, s);
      check(32'(r), 32'(RESP_SLVERR));
      $display("register map test done");

      core.wr(PTR_OFS, 32'h0, r, s);
      core.launch(32'h8003, r, s);
      op_done(1012);
      for (int i = 0; i < BLOCK_WORDS; i++) flash_m[i] = ERASED_WORD;
      sweep(0, BLOCK_WORDS - 1);
      $display("erase test done");

      for (int i = 0; i < ROW_WORDS; i++) load(ROW_WORDS + i, 24'(rnd()));
      repeat (20) load(ROW_WORDS + int'(rnd() % 32'h40), 24'(rnd()));
      sweep(ROW_WORDS, 2 * ROW_WORDS - 1);
      core.wr(PTR_OFS, 32'(ROW_WORDS), r, s);
      core.launch(32'h8002, r, s);
      op_done(314);
      for (int i = 0; i < ROW_WORDS; i++) flash_m[ROW_WORDS + i] &= latch_m[i];
      sweep(0, BLOCK_WORDS - 1);
      $display("row program test done");

      load(200, 24'(rnd()));
      core.launch(32'h8001, r, s);
      op_done(251);
      flash_m[200] &= latch_m[200 % ROW_WORDS];
      sweep(128, 255);
      $display("word program test done");

      // Row 4 is still erased, so a start that slipped through would show
      core.wr(KEY_OFS, {24'h0, KEY_FIRST}, r, s);
      core.wr(KEY_OFS, {24'h0, KEY_SECOND}, r, s);
      core.rd(STAT_OFS, d, r);
      check(d, 32'h2);
      // The pointer write between key pair and go must disarm
      core.wr(PTR_OFS, 32'h100, r, s);
      for (int c = 0; c < 4; c++) begin
         if (c == 1) begin
            core.wr(KEY_OFS, {24'h0, KEY_FIRST}, r, s);
            core.wr(PTR_OFS, 32'h100, r, s);
            core.wr(KEY_OFS, {24'h0, KEY_SECOND}, r, s);
         end
         if (c >= 2) core.launch((c == 2) ? 32'hc002 : 32'h8000, r, s);
         else core.wr(CTRL_OFS, 32'h8002, r, s);
         check(32'(r), 32'(RESP_OKAY));
         check(32'(s), 32'h0);
         core.rd(STAT_OFS, d, r);
         check(d, 32'h4);
         core.rd(CTRL_OFS, d, r);
         check(32'(d[CTRL_GO_BIT]), 32'h0);
         core.wr(STAT_OFS, 32'h4, r, s);
      end
      core.rd(STAT_OFS, d, r);
      check(d & 32'h4, 32'h0);
      sweep(0, BLOCK_WORDS - 1);
      $display("refused start test done");
      results();
   end
endmodule
